// ==== inc/wed_regs.svh ====
// Timing figures and counter slot numbers for the wake exit delay block
`ifndef WED_REGS_SVH
`define WED_REGS_SVH

// ----------------------------------------------------------------
// Core clock
// ----------------------------------------------------------------
`define WED_CLK_PERIOD_NS 10

// ----------------------------------------------------------------
// Delay figures in ns (plain defaults, retune per process)
// ----------------------------------------------------------------
`define WED_CPU_PREP_NS   10000
`define WED_START_UP_NS   25600
`define WED_PLL_LOCK_NS   2000000
`define WED_SETTLE_NS     1000000

// ----------------------------------------------------------------
// Counter slots
// ----------------------------------------------------------------
`define WED_IDX_PREP      0
`define WED_IDX_START     1
`define WED_IDX_PLL       2
`define WED_IDX_SETTLE    3
`define WED_NUM_CNT       4

`endif

// ==== inc/wed_pkg.sv ====
// Types shared by the wake exit delay block
package wed_pkg;

    // Clock source running before the wake event
    typedef enum logic [1:0] {
        WED_FROM_PRIMARY  = 2'h0,   // Primary idle, source kept running
        WED_FROM_SLOW_SEC = 2'h1,   // Secondary crystal or slow internal
        WED_FROM_FAST     = 2'h2,   // Fast internal block or a postscaled tap
        WED_FROM_SLEEP    = 2'h3    // Sleep, nothing running
    } wed_src_e;

    // Clock mode selected after the wake event
    typedef enum logic [3:0] {
        WED_LOW_POWER_CRYSTAL  = 4'h0,
        WED_CRYSTAL_MODE       = 4'h1,
        WED_HIGH_SPEED_CRYSTAL = 4'h2,
        WED_HIGH_SPEED_MULT    = 4'h3,   // High speed crystal through the multiplier
        WED_RESISTOR_CAP       = 4'h4,
        WED_EXTERNAL_CLOCK     = 4'h5,
        WED_INTERNAL_OSC_IO    = 4'h6,
        WED_SLOW_INTERNAL      = 4'h7,
        WED_FAST_INTERNAL      = 4'h8
    } wed_mode_e;

    // Sequencer states, one-hot
    typedef enum logic [1:0] {
        WED_RUN  = 2'h1,
        WED_HOLD = 2'h2
    } wed_fsm_e;

    // Whole state of the sequencer
    typedef struct packed {
        wed_fsm_e fsm;
        logic     pll_pend;
        logic     settle_pend;
        logic     pri_ready;
        logic     int_stable;
        logic     resume;
    } wed_state_s;

endpackage

// ==== verilog/wed_delay_counter.sv ====
// Loadable down counter that times one wake-up interval
module wed_delay_counter #(
    parameter int unsigned CNT_W = 24
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             reset_n,
    // Load request
    input  wire logic             start,
    input  wire logic [CNT_W-1:0] length,
    // Progress
    output logic                  busy,
    output logic                  done
);

    // Counter state: remaining cycles and end pulse
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             done;
    } wed_cnt_s;

    wed_cnt_s st_reg;   // Registered state
    wed_cnt_s st_next;  // Next state

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        st_next      = st_reg;
        st_next.done = 1'b0;
        // A new load restarts the interval even mid-count
        if (start) begin
            st_next.cnt = length;
        end else if (st_reg.cnt != '0) begin
            st_next.cnt  = st_reg.cnt - 1'b1;
            st_next.done = (st_reg.cnt == {{(CNT_W-1){1'b0}}, 1'b1});
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Busy for exactly length cycles, done in the first idle cycle
    assign busy = (st_reg.cnt != '0);
    assign done = st_reg.done;

endmodule

// ==== verilog/wed_wake_exit.sv ====
// Wake-up exit delay sequencer that holds and releases the core
`include "wed_regs.svh"

// Function
// - Primary idle wake: prepare delay only
// - No start-up timer for external, resistor, io modes
// - Prepare delay after every Sleep/Idle wake
// - Resume on second cycle after delay
// - Prepare delay runs alongside other delays
// - Crystal targets: start-up interval, then ready
// - Multiplier target: start-up then lock interval
// - Fast internal: run on, flag when settled
// - Ready flag chosen by target mode
// - Slow internal target: prepare only, no flag
// - Fast internal taps treated alike
// - Primary ready after timer expiry, or at the wake in primary idle
// - Internal stable only once block settled
module wed_wake_exit
    import wed_pkg::*;
#(
    parameter int unsigned CNT_W      = 24,
    parameter int unsigned PREP_CYC   =
        (`WED_CPU_PREP_NS + `WED_CLK_PERIOD_NS - 1) / `WED_CLK_PERIOD_NS,
    parameter int unsigned START_CYC  =
        (`WED_START_UP_NS + `WED_CLK_PERIOD_NS - 1) / `WED_CLK_PERIOD_NS,
    parameter int unsigned PLL_CYC    =
        (`WED_PLL_LOCK_NS + `WED_CLK_PERIOD_NS - 1) / `WED_CLK_PERIOD_NS,
    parameter int unsigned SETTLE_CYC =
        (`WED_SETTLE_NS + `WED_CLK_PERIOD_NS - 1) / `WED_CLK_PERIOD_NS
) (
    // Clock and reset
    input  wire logic          core_clk,
    input  wire logic          reset_n,
    // Wake event source
    input  wire logic          wake_event,
    input  wed_pkg::wed_src_e  before_src,
    input  wed_pkg::wed_mode_e target_mode,
    // Core release
    output logic               core_stall,
    output logic               core_resume,
    // Clock ready status
    output logic               primary_ready_flag,
    output logic               internal_stable_flag
);
    import wed_pkg::*;

    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    // A zero length would never raise busy and would skip a delay
    if (PREP_CYC < 1 || START_CYC < 1 || PLL_CYC < 1 || SETTLE_CYC < 1) begin : g_chk_len
        $error("wed_wake_exit: every delay needs at least one cycle");
    end
    if (CNT_W > 31 || PREP_CYC >= (1 << CNT_W) || START_CYC >= (1 << CNT_W) ||
        PLL_CYC >= (1 << CNT_W) || SETTLE_CYC >= (1 << CNT_W)) begin : g_chk_w
        $error("wed_wake_exit: counter width too small for a delay");
    end

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    // Crystal family modes that need the start-up timer from cold
    function automatic logic is_crystal(input wed_mode_e m);
        is_crystal = (m == WED_LOW_POWER_CRYSTAL) || (m == WED_CRYSTAL_MODE) ||
                     (m == WED_HIGH_SPEED_CRYSTAL) || (m == WED_HIGH_SPEED_MULT);
    endfunction

    // Start-up timer only when the crystal was actually stopped
    function automatic logic needs_start(input wed_src_e s, input wed_mode_e m);
        needs_start = is_crystal(m) && (s != WED_FROM_PRIMARY);
    endfunction

    // Settling only when the fast block was not already clocking
    function automatic logic needs_settle(input wed_src_e s, input wed_mode_e m);
        needs_settle = (m == WED_FAST_INTERNAL) && (s != WED_FROM_FAST);
    endfunction

    // Length of each counter slot
    function automatic logic [CNT_W-1:0] cnt_len(input int unsigned idx);
        case (idx)
            `WED_IDX_PREP: cnt_len = CNT_W'(PREP_CYC);
            `WED_IDX_START: cnt_len = CNT_W'(START_CYC);
            `WED_IDX_PLL:  cnt_len = CNT_W'(PLL_CYC);
            default:       cnt_len = CNT_W'(SETTLE_CYC);
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    localparam wed_state_s RST_STATE = '{fsm: WED_RUN, default: '0};

    wed_state_s             st_reg;    // Registered state
    wed_state_s             st_next;   // Next state
    logic [`WED_NUM_CNT-1:0] start_vec; // Counter load strobes
    logic [`WED_NUM_CNT-1:0] busy_vec;  // Counter running
    logic [`WED_NUM_CNT-1:0] done_vec;  // Counter end pulses
    logic                   wake_ok;   // Wake taken this cycle
    logic                   hold_busy; // Any stalling delay still open
    logic                   pri_cause; // Event that may raise the primary flag
    logic                   int_cause; // Event that may raise the stable flag

    // Wake events while already holding are ignored
    assign wake_ok = wake_event && (st_reg.fsm == WED_RUN);

    // Settling does not stall the core, so it is left out here
    assign hold_busy = busy_vec[`WED_IDX_PREP] | busy_vec[`WED_IDX_START] |
                       busy_vec[`WED_IDX_PLL];

    // Only these events may raise a flag; the checks below watch them
    assign pri_cause = done_vec[`WED_IDX_START] | done_vec[`WED_IDX_PLL] | wake_ok;
    assign int_cause = done_vec[`WED_IDX_SETTLE] | wake_ok;

    // ----------------------------------------------------------------
    // Delay counters, one per interval
    // ----------------------------------------------------------------
    for (genvar i = 0; i < `WED_NUM_CNT; i++) begin : g_cnt
        wed_delay_counter #(
            .CNT_W (CNT_W)
        ) u_cnt (
            .core_clk (core_clk),
            .reset_n  (reset_n),
            .start    (start_vec[i]),
            .length   (cnt_len(i)),
            .busy     (busy_vec[i]),
            .done     (done_vec[i])
        );
    end

    // ----------------------------------------------------------------
    // Sequencer next state
    // ----------------------------------------------------------------
    always_comb begin
        st_next        = st_reg;
        st_next.resume = 1'b0;
        start_vec      = '0;
        // Settling end; a wake in the same cycle overrides it below
        if (done_vec[`WED_IDX_SETTLE] && st_reg.settle_pend) begin
            st_next.int_stable  = 1'b1;
            st_next.settle_pend = 1'b0;
        end
        case (st_reg.fsm)
            WED_RUN: begin
                if (wake_event) begin
                    st_next.fsm = WED_HOLD;
                    // Prepare delay always, in parallel with the rest
                    start_vec[`WED_IDX_PREP] = 1'b1;
                    // Crystal start-up only from a stopped crystal
                    start_vec[`WED_IDX_START] = needs_start(before_src, target_mode);
                    // Lock interval queued behind the start-up timer
                    st_next.pll_pend = needs_start(before_src, target_mode) &&
                                       (target_mode == WED_HIGH_SPEED_MULT);
                    // Crystal already running in primary idle gets its flag at once
                    st_next.pri_ready = is_crystal(target_mode) &&
                                        (before_src == WED_FROM_PRIMARY);
                    // Fast block already running: no settling, stable at once
                    st_next.int_stable = (target_mode == WED_FAST_INTERNAL) &&
                                         (before_src == WED_FROM_FAST);
                    st_next.settle_pend = needs_settle(before_src, target_mode);
                    start_vec[`WED_IDX_SETTLE] = needs_settle(before_src, target_mode);
                end
            end
            WED_HOLD: begin
                if (done_vec[`WED_IDX_START] && st_reg.pll_pend) begin
                    // Timer expired, now wait for lock
                    start_vec[`WED_IDX_PLL] = 1'b1;
                    st_next.pll_pend        = 1'b0;
                end else if (done_vec[`WED_IDX_START]) begin
                    st_next.pri_ready = 1'b1;
                end
                if (done_vec[`WED_IDX_PLL]) begin
                    st_next.pri_ready = 1'b1;
                end
                // Release once every stalling counter has finished
                if (!hold_busy && !st_reg.pll_pend) begin
                    st_next.fsm    = WED_RUN;
                    st_next.resume = 1'b1;
                end
            end
            default: begin
                st_next = RST_STATE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            st_reg <= RST_STATE;
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign core_stall           = (st_reg.fsm == WED_HOLD);
    assign core_resume          = st_reg.resume;
    assign primary_ready_flag   = st_reg.pri_ready;
    assign internal_stable_flag = st_reg.int_stable;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    sequence wake_taken_s;
        wake_ok;
    endsequence

    sequence held_s;
        core_stall && busy_vec[`WED_IDX_PREP];
    endsequence

    resume_after_hold_a: assert property ($fell(core_stall) |-> core_resume)
        else $error("core released without resume pulse");
    no_early_resume_a: assert property (hold_busy |-> core_stall && !core_resume)
        else $error("core released while a delay runs");
    prep_every_wake_a: assert property (wake_taken_s |=> held_s)
        else $error("prepare delay missing after wake");
    idle_no_timer_a: assert property (
        wake_taken_s ##0 (before_src == WED_FROM_PRIMARY) |=> !busy_vec[`WED_IDX_START])
        else $error("start-up timer run from primary idle");
    plain_no_timer_a: assert property (wake_taken_s ##0 !is_crystal(target_mode)
        |=> !busy_vec[`WED_IDX_START] && !busy_vec[`WED_IDX_PLL])
        else $error("start-up timer run for non-crystal mode");
    timer_then_lock_a: assert property (
        done_vec[`WED_IDX_START] && st_reg.pll_pend |=> busy_vec[`WED_IDX_PLL]
        && core_stall && !primary_ready_flag)
        else $error("lock interval did not follow start-up");
    pri_flag_cause_a: assert property ($rose(primary_ready_flag) |-> $past(pri_cause))
        else $error("primary ready set without timer expiry");
    int_flag_cause_a: assert property ($rose(internal_stable_flag) |-> $past(int_cause))
        else $error("internal stable set before settling");
    slow_no_flag_a: assert property (wake_taken_s ##0 (target_mode == WED_SLOW_INTERNAL)
        |=> !primary_ready_flag && !internal_stable_flag)
        else $error("flag set for slow internal target");
    fast_run_on_a: assert property (wake_taken_s ##0 (target_mode == WED_FAST_INTERNAL)
        |=> !busy_vec[`WED_IDX_START])
        else $error("fast internal target stalled on timer");

endmodule

// ==== testbench/wed_core_model.sv ====
// Processor core model that waits for release after a wake-up
module wed_core_model (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    // Release from the sequencer
    input  wire logic       core_stall,
    input  wire logic       core_resume,
    // What the core saw
    output logic [7:0]      last_hold,
    output logic            order_err
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [7:0] run_len;    // Stall cycles of the hold in progress

    // ------------------------------------------------------------
    // Hold counting and release judgement
    // ------------------------------------------------------------
    // Counts every stalled cycle, so an early or silent release shows
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            run_len   <= 8'h00;
            last_hold <= 8'h00;
            order_err <= 1'b0;
        end else if (core_stall) begin
            run_len <= run_len + 8'h01;
            // Never told to run while still held
            if (core_resume) order_err <= 1'b1;
        end else if (core_resume) begin
            // Resume belongs to the first cycle after a hold
            if (run_len == 8'h00) order_err <= 1'b1;
            last_hold <= run_len;
            run_len   <= 8'h00;
        end else if (run_len != 8'h00) begin
            // Hold ended with no resume pulse
            order_err <= 1'b1;
        end
    end
endmodule

// ==== testbench/testbench.sv ====
// Self-checking bench for the wake exit delay sequencer
`define WED_CHECK(what, exp, got) begin num_checks++; if ((got) !== (exp)) begin \
    bad_count++; $display("unexpected %s exp %0h got %0h", what, exp, got); end end

module testbench;
    import wed_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------
    // Shortened delays and the hold lengths they imply
    // ------------------------------------------------------------
    localparam int PREP = 3;
    localparam int START = 5;
    localparam int PLL = 7;
    localparam int SETTLE = 4;
    localparam int LEN_PREP = PREP + 1;                           // Stall is delay plus one
    localparam int LEN_START = ((START > PREP) ? START : PREP) + 1; // Longer of the two wins
    localparam int LEN_PLL = ((START + 1 + PLL > PREP) ? START + 1 + PLL : PREP) + 1;

    logic       core_clk = 1'b0;          // 100 MHz core clock
    logic       reset_n = 1'b0;           // Synchronous reset, low active
    logic       wake_event = 1'b0;        // Wake pulse
    wed_src_e   before_src = WED_FROM_SLEEP;
    wed_mode_e  target_mode = WED_LOW_POWER_CRYSTAL;
    logic       core_stall;
    logic       core_resume;
    logic       primary_ready_flag;
    logic       internal_stable_flag;
    logic [7:0] last_hold;                // Hold length the core saw
    logic       order_err;                // Core saw a bad release
    int         bad_count = 0;
    int         num_checks = 0;

    always #5 core_clk = ~core_clk;

    wed_wake_exit #(.PREP_CYC(PREP), .START_CYC(START), .PLL_CYC(PLL), .SETTLE_CYC(SETTLE)) dut (
        .core_clk(core_clk), .reset_n(reset_n), .wake_event(wake_event),
        .before_src(before_src), .target_mode(target_mode), .core_stall(core_stall),
        .core_resume(core_resume), .primary_ready_flag(primary_ready_flag),
        .internal_stable_flag(internal_stable_flag));

    wed_core_model core (
        .core_clk(core_clk), .reset_n(reset_n), .core_stall(core_stall),
        .core_resume(core_resume), .last_hold(last_hold), .order_err(order_err));

    // ------------------------------------------------------------
    // Verdict, reached from the end of the run or a timeout
    // ------------------------------------------------------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // One wake and its whole hold; poke retries a wake while held
    task automatic wake_check(input wed_src_e src, input wed_mode_e mode, input int exp_len,
                              input logic exp_pri, input logic exp_int, input logic poke);
        int n;
        n = 0;
        @(negedge core_clk);
        wake_event = 1'b1;
        before_src = src;
        target_mode = mode;
        @(negedge core_clk);
        wake_event = 1'b0;
        `WED_CHECK("stall after wake", 1'b1, core_stall)
        `WED_CHECK("flag in hold", exp_pri && src == WED_FROM_PRIMARY, primary_ready_flag)
        while (core_stall === 1'b1 && n < 60) begin
            n++;
            // Refused wake aimed at a target with no start-up delay or flag
            if (poke) wake_event = (n == 3);
            if (poke) target_mode = WED_SLOW_INTERNAL;
            @(negedge core_clk);
        end
        wake_event = 1'b0;
        if (n >= 60) begin
            bad_count++;
            complete_run();
        end
        `WED_CHECK("hold length", exp_len, n)
        `WED_CHECK("resume pulse", 1'b1, core_resume)
        `WED_CHECK("primary flag at release", exp_pri, primary_ready_flag)
        if (src != WED_FROM_FAST) `WED_CHECK("stable early", 1'b0, internal_stable_flag)
        @(negedge core_clk);
        `WED_CHECK("resume one cycle", 1'b0, core_resume)
        `WED_CHECK("core hold count", 8'(exp_len), last_hold)
        @(negedge core_clk);
        `WED_CHECK("stable flag", exp_int, internal_stable_flag)
        `WED_CHECK("primary flag kept", exp_pri, primary_ready_flag)
        // Judged per wake, since a later reset clears the model's record
        `WED_CHECK("release order", 1'b0, order_err)
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Primary idle: every target gets the prepare delay only
    task automatic test_primary_idle();
        for (int m = 0; m <= 8; m++) begin
            wake_check(WED_FROM_PRIMARY, wed_mode_e'(m), LEN_PREP, m <= 3, m == 8, 1'b0);
        end
        $display("test primary_idle done");
    endtask

    // Stopped crystal targets wait out the start-up timer
    task automatic test_crystal();
        for (int s = 1; s <= 3; s++) begin
            for (int m = 0; m <= 2; m++) begin
                wake_check(wed_src_e'(s), wed_mode_e'(m), LEN_START, 1'b1, 1'b0, 1'b0);
            end
            wake_check(wed_src_e'(s), WED_HIGH_SPEED_MULT, LEN_PLL, 1'b1, 1'b0, 1'b0);
        end
        $display("test crystal done");
    endtask

    // Modes with no start-up timer and the slow internal target
    task automatic test_no_timer();
        for (int s = 1; s <= 3; s++) begin
            for (int m = 4; m <= 7; m++) begin
                wake_check(wed_src_e'(s), wed_mode_e'(m), LEN_PREP, 1'b0, 1'b0, 1'b0);
            end
        end
        $display("test no_timer done");
    endtask

    // Fast internal target: run on during settling, taps alike
    task automatic test_fast_internal();
        wake_check(WED_FROM_SLEEP, WED_FAST_INTERNAL, LEN_PREP, 1'b0, 1'b1, 1'b0);
        wake_check(WED_FROM_SLOW_SEC, WED_FAST_INTERNAL, LEN_PREP, 1'b0, 1'b1, 1'b0);
        wake_check(WED_FROM_FAST, WED_FAST_INTERNAL, LEN_PREP, 1'b0, 1'b1, 1'b0);
        $display("test fast_internal done");
    endtask

    // A wake offered during a hold changes nothing
    task automatic test_refused();
        wake_check(WED_FROM_SLEEP, WED_HIGH_SPEED_MULT, LEN_PLL, 1'b1, 1'b0, 1'b1);
        $display("test refused done");
    endtask

    // Reset in mid-hold clears everything, then a clean wake
    task automatic test_reset_mid_hold();
        @(negedge core_clk);
        wake_event = 1'b1;
        before_src = WED_FROM_SLEEP;
        target_mode = WED_HIGH_SPEED_MULT;
        @(negedge core_clk);
        wake_event = 1'b0;
        repeat (3) @(negedge core_clk);
        reset_n = 1'b0;
        repeat (2) @(negedge core_clk);
        `WED_CHECK("stall in reset", 1'b0, core_stall)
        `WED_CHECK("resume in reset", 1'b0, core_resume)
        `WED_CHECK("flags in reset", 2'h0, {primary_ready_flag, internal_stable_flag})
        reset_n = 1'b1;
        wake_check(WED_FROM_SLEEP, WED_CRYSTAL_MODE, LEN_START, 1'b1, 1'b0, 1'b0);
        $display("test reset_mid_hold done");
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(negedge core_clk);
        `WED_CHECK("reset outputs", 4'h0,
                   {core_stall, core_resume, primary_ready_flag, internal_stable_flag})
        reset_n = 1'b1;
        test_primary_idle();
        test_crystal();
        test_no_timer();
        test_fast_internal();
        test_refused();
        test_reset_mid_hold();
        `WED_CHECK("core release order", 1'b0, order_err)
        complete_run();
    end
endmodule
